/* hdl/ccpc_channel.sv */
// Compare/PWM channel top: compare actions, PWM generation, trigger.
// Operation
// - Instruction-clocked event timer halts in sleep and resumes afterward.
// - Externally clocked event timer keeps counting through sleep.
// - Compare value pair is compared continuously against event timer count.
// - A match toggles, sets, clears, pulses or only flags, per mode.
// - Every compare match sets the match flag, may trigger conversion.
// - Writing zero control forces the compare output latch low.
// - Channel output is also offered internally to other peripherals.
// - Conversion trigger only when this channel is the selected source.
// - Changed compare value before reset edge cancels the timer reset.
// - Compare in sleep needs a running timer; enabled match wakes device.
// - PWM mode gives up to 10-bit duty using the period timer.
// - PWM period is (limit+1) times 4 times Tosc times prescale.
// - After limit match: counter clears, output sets unless zero, duty buffered.
// - The period timer postscaler has no effect on PWM frequency.
// - Duty comes from compare value pair, left or right aligned.
// - Duty writable anytime, takes effect at next period match.
// - Time base is counter plus two low bits from clock or prescaler.
// - Output clears when time base equals the buffered duty.
// - Duty beyond the period leaves the output unchanged.
`default_nettype none
`timescale 1ns/1ns
module ccpc_channel (
  input  wire logic                   clk_in,
  input  wire logic                   nrst_in,
  input  wire logic [7:0]             channel_control_in,
  input  wire logic                   channel_control_wr_in,
  input  wire logic [15:0]            compare_value_pair_in,
  input  wire logic                   compare_value_wr_in,
  input  wire ccpc_pkg::ccpc_ptimer_t period_timer_control_in,
  input  wire logic                   event_timer_run_in,
  input  wire logic                   event_ext_clk_sel_in,
  input  wire logic                   event_ext_tick_in,
  input  wire logic                   sleep_in,
  input  wire logic                   trigger_source_sel_in,
  input  wire logic                   match_int_enable_in,
  input  wire logic                   flag_clear_in,
  output logic                        channel_output_out,
  output logic                        channel_output_internal_out,
  output logic                        channel_match_flag_out,
  output logic                        period_timer_flag_out,
  output logic                        conversion_trigger_out,
  output logic                        wake_out,
  output logic [15:0]                 event_timer_count_out,
  output logic [7:0]                  period_counter_out
);
  import ccpc_pkg::*;

  ccpc_ctrl_t  ctrl_q;
  logic [15:0] cmp_q;
  logic [9:0]  duty_buf_q;
  logic        out_q;
  logic        flag_q;
  logic        pflag_q;
  logic        trig_q;
  logic        pulse_q;
  logic        clr_pend_q;
  logic        ev_tick;
  logic        wrap;
  logic [9:0]  base;
  logic [9:0]  duty_new;
  logic        is_pwm;
  logic        is_cmp;
  logic        match;
  logic        clr_mode;

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      ctrl_q <= '0;
    end else if (channel_control_wr_in) begin
      ctrl_q.enable     <= channel_control_in[CTRL_EN_BIT];
      ctrl_q.align_left <= channel_control_in[CTRL_FMT_BIT];
      ctrl_q.mode       <= channel_control_in[3:0];
    end
  end

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      cmp_q <= 16'h0000;
    end else if (compare_value_wr_in) begin
      cmp_q <= compare_value_pair_in;
    end
  end

  assign is_pwm   = ctrl_q.enable && ctrl_q.mode == MODE_PWM;
  assign is_cmp   = ctrl_q.enable && !is_pwm && ctrl_q.mode != MODE_OFF;
  assign clr_mode = ctrl_q.mode == MODE_TOG_CLR ||
                    ctrl_q.mode == MODE_PULSE_CL;

  ccpc_event_timer u_event (
    .clk_in         (clk_in),
    .nrst_in        (nrst_in),
    .run_in         (event_timer_run_in),
    .ext_clk_sel_in (event_ext_clk_sel_in),
    .ext_tick_in    (event_ext_tick_in),
    .sleep_in       (sleep_in),
    .clear_in       (clr_pend_q && ev_tick && !compare_value_wr_in),
    .tick_out       (ev_tick),
    .count_out      (event_timer_count_out)
  );

  ccpc_period_timer u_period (
    .clk_in    (clk_in),
    .nrst_in   (nrst_in),
    .cfg_in    (period_timer_control_in),
    .sleep_in  (sleep_in),
    .wrap_out  (wrap),
    .base_out  (base),
    .count_out (period_counter_out)
  );

  assign match = is_cmp && ev_tick &&
                 event_timer_count_out + 16'h0001 == cmp_q;

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      clr_pend_q <= 1'b0;
    end else if (compare_value_wr_in || !is_cmp) begin
      clr_pend_q <= 1'b0;
    end else if (match && clr_mode) begin
      clr_pend_q <= 1'b1;
    end else if (ev_tick) begin
      clr_pend_q <= 1'b0;
    end
  end

  assign duty_new = ctrl_q.align_left ? cmp_q[15:6] : cmp_q[9:0];

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      duty_buf_q <= 10'h000;
    end else if (wrap) begin
      duty_buf_q <= duty_new;
    end
  end

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      out_q   <= 1'b0;
      pulse_q <= 1'b0;
    end else if (!ctrl_q.enable) begin
      out_q   <= 1'b0;
      pulse_q <= 1'b0;
    end else if (is_pwm) begin
      pulse_q <= 1'b0;
      if (wrap) begin
        out_q <= duty_new != 10'h000;
      // clear at duty; beyond period never matches
      end else if (base == duty_buf_q) begin
        out_q <= 1'b0;
      end
    end else if (match) begin
      case (ctrl_q.mode)
        MODE_TOG_CLR,
        MODE_TOGGLE:   out_q <= !out_q;
        MODE_SET:      out_q <= 1'b1;
        MODE_CLEAR:    out_q <= 1'b0;
        MODE_PULSE,
        MODE_PULSE_CL: begin
          out_q   <= 1'b1;
          pulse_q <= 1'b1;
        end
        default:       out_q <= out_q;
      endcase
    end else if (pulse_q) begin
      out_q   <= 1'b0;
      pulse_q <= 1'b0;
    end
  end

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      flag_q <= 1'b0;
    end else if (match) begin
      flag_q <= 1'b1;
    end else if (flag_clear_in) begin
      flag_q <= 1'b0;
    end
  end

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      pflag_q <= 1'b0;
    end else if (wrap) begin
      pflag_q <= 1'b1;
    end else if (flag_clear_in) begin
      pflag_q <= 1'b0;
    end
  end

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      trig_q <= 1'b0;
    end else begin
      trig_q <= match && trigger_source_sel_in;
    end
  end

  assign channel_output_out          = out_q;
  assign channel_output_internal_out = out_q;
  assign channel_match_flag_out      = flag_q;
  assign period_timer_flag_out       = pflag_q;
  assign conversion_trigger_out      = trig_q;
  assign wake_out = flag_q && match_int_enable_in;
endmodule // ccpc_channel
`default_nettype wire

/* common/ccpc_pkg.sv */
// Shared constants and carrier types for the compare/PWM channel.
`default_nettype none
package ccpc_pkg;
  localparam logic [3:0] MODE_OFF      = 4'h0;
  localparam logic [3:0] MODE_TOG_CLR  = 4'h1;
  localparam logic [3:0] MODE_TOGGLE   = 4'h2;
  localparam logic [3:0] MODE_SET      = 4'h8;
  localparam logic [3:0] MODE_CLEAR    = 4'h9;
  localparam logic [3:0] MODE_PULSE    = 4'hA;
  localparam logic [3:0] MODE_PULSE_CL = 4'hB;
  localparam logic [3:0] MODE_PWM      = 4'hF;
  localparam int         CTRL_W        = 8;
  localparam int         CTRL_EN_BIT   = 7;
  localparam int         CTRL_FMT_BIT  = 4;
  localparam logic [7:0] CTRL_RESET    = 8'h00;
  localparam int         PRESC_W       = 2;
  localparam logic [1:0] PRESC_1       = 2'h0;
  localparam logic [1:0] PRESC_4       = 2'h1;
  localparam logic [1:0] PRESC_16      = 2'h2;
  localparam logic [1:0] PRESC_64      = 2'h3;
  localparam int         SYS_PER_INSTR = 4;

  typedef struct packed {
    logic       enable;
    logic       align_left;
    logic [3:0] mode;
  } ccpc_ctrl_t;

  typedef struct packed {
    logic       run;
    logic [1:0] prescale_sel;
    logic [7:0] limit;
  } ccpc_ptimer_t;
endpackage
`default_nettype wire

/* hdl/ccpc_event_timer.sv */
// Sixteen-bit event timer with instruction-clock or external tick source.
`default_nettype none
`timescale 1ns/1ns
module ccpc_event_timer (
  input  wire logic        clk_in,
  input  wire logic        nrst_in,
  input  wire logic        run_in,
  input  wire logic        ext_clk_sel_in,
  input  wire logic        ext_tick_in,
  input  wire logic        sleep_in,
  input  wire logic        clear_in,
  output logic             tick_out,
  output logic [15:0]      count_out
);
  import ccpc_pkg::*;
  logic [1:0] div_q;
  logic       inc;

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      div_q <= 2'h0;
    end else if (!sleep_in) begin
      div_q <= div_q + 2'h1;
    end
  end

  assign inc = run_in && (ext_clk_sel_in ? ext_tick_in :
               (!sleep_in && div_q == 2'(SYS_PER_INSTR - 1)));
  assign tick_out = inc;

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      count_out <= 16'h0000;
    end else if (clear_in) begin
      count_out <= 16'h0000;
    end else if (inc) begin
      count_out <= count_out + 16'h0001;
    end
  end
endmodule // ccpc_event_timer
`default_nettype wire

/* hdl/ccpc_period_timer.sv */
// Eight-bit period timer with prescaler and two-bit fine time base.
`default_nettype none
`timescale 1ns/1ns
module ccpc_period_timer (
  input  wire logic                   clk_in,
  input  wire logic                   nrst_in,
  input  wire ccpc_pkg::ccpc_ptimer_t cfg_in,
  input  wire logic                   sleep_in,
  output logic                        wrap_out,
  output logic [9:0]                  base_out,
  output logic [7:0]                  count_out
);
  import ccpc_pkg::*;
  logic [7:0] pre_q;
  logic [7:0] pre_max;
  logic       inc;
  logic [1:0] fine;

  always_comb begin
    case (cfg_in.prescale_sel)
      PRESC_1:  pre_max = 8'h03;
      PRESC_4:  pre_max = 8'h0F;
      PRESC_16: pre_max = 8'h3F;
      default:  pre_max = 8'hFF;
    endcase
  end

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      pre_q <= 8'h00;
    end else if (!cfg_in.run) begin
      pre_q <= 8'h00;
    end else if (!sleep_in) begin
      pre_q <= (pre_q == pre_max) ? 8'h00 : pre_q + 8'h01;
    end
  end

  assign inc      = cfg_in.run && !sleep_in && pre_q == pre_max;
  assign wrap_out = inc && count_out == cfg_in.limit;

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      count_out <= 8'h00;
    end else if (wrap_out) begin
      count_out <= 8'h00;
    end else if (inc) begin
      count_out <= count_out + 8'h01;
    end
  end

  always_comb begin
    case (cfg_in.prescale_sel)
      PRESC_1:  fine = pre_q[1:0];
      PRESC_4:  fine = pre_q[3:2];
      PRESC_16: fine = pre_q[5:4];
      default:  fine = pre_q[7:6];
    endcase
  end
  assign base_out = {count_out, fine};
endmodule // ccpc_period_timer
`default_nettype wire

/* sim/ccpc_pin_load.sv */
// Far-side model: a pulled-down pin load and a conversion trigger counter.
`default_nettype none
`timescale 1ns/1ns
module ccpc_pin_load (
  input  wire logic       clk_in,
  input  wire logic       nrst_in,
  input  wire logic       pin_in,
  input  wire logic       drive_en_in,
  input  wire logic       measure_in,
  input  wire logic       trigger_in,
  output logic [7:0]      high_cnt_out,
  output logic [7:0]      trig_cnt_out
);
  // The pull-down makes an undriven pin read low, never a stale value.
  logic level;
  assign level = drive_en_in & pin_in;
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) high_cnt_out <= 8'h00;
    else if (!measure_in) high_cnt_out <= 8'h00;
    else if (level) high_cnt_out <= high_cnt_out + 8'h01;
  end
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) trig_cnt_out <= 8'h00;
    else if (trigger_in) trig_cnt_out <= trig_cnt_out + 8'h01;
  end
endmodule // ccpc_pin_load
`default_nettype wire

/* sim/ccpc_channel_checker.sv */
// Port-level assertions for the compare/PWM channel.
`default_nettype none
`timescale 1ns/1ns
module ccpc_channel_checker (
  input wire logic                   clk_in,
  input wire logic                   nrst_in,
  input wire logic [7:0]             channel_control_in,
  input wire logic                   channel_control_wr_in,
  input wire ccpc_pkg::ccpc_ptimer_t period_timer_control_in,
  input wire logic                   event_ext_clk_sel_in,
  input wire logic                   sleep_in,
  input wire logic                   trigger_source_sel_in,
  input wire logic                   match_int_enable_in,
  input wire logic                   flag_clear_in,
  input wire logic                   channel_output_out,
  input wire logic                   channel_output_internal_out,
  input wire logic                   channel_match_flag_out,
  input wire logic                   period_timer_flag_out,
  input wire logic                   conversion_trigger_out,
  input wire logic                   wake_out,
  input wire logic [15:0]            event_timer_count_out,
  input wire logic [7:0]             period_counter_out
);
  import ccpc_pkg::*;
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!nrst_in);
  chk_trig_src_sel: assert property (
    conversion_trigger_out |-> $past(trigger_source_sel_in))
    else $error("trigger without source select");
  chk_trig_has_flag: assert property (
    $rose(conversion_trigger_out) |-> channel_match_flag_out)
    else $error("trigger without match flag");
  chk_out_internal: assert property (
    channel_output_internal_out == channel_output_out)
    else $error("internal output differs from pin");
  chk_wake_enable: assert property (
    wake_out == (channel_match_flag_out && match_int_enable_in))
    else $error("wake does not follow flag and enable");
  // The cleared enable reaches the output latch one edge after the write.
  chk_ctrl_zero_low: assert property (
    channel_control_wr_in && channel_control_in == 8'h00
    |=> ##1 !channel_output_out) else $error("zero control left output high");
  // Two cycles of sleep rule out a tick already in flight.
  chk_sleep_hold: assert property (
    sleep_in && $past(sleep_in) && !event_ext_clk_sel_in
    && !$past(event_ext_clk_sel_in) |=> $stable(event_timer_count_out))
    else $error("event timer moved in sleep");
  chk_pwm_wrap: assert property (
    $changed(period_counter_out)
    && $past(period_counter_out) == $past(period_timer_control_in.limit)
    |-> period_counter_out == 8'h00) else $error("period wrap not to zero");
  chk_flag_sticky: assert property (
    channel_match_flag_out && !flag_clear_in |=> channel_match_flag_out)
    else $error("match flag dropped");
  cov_trigger: cover property ($rose(conversion_trigger_out));
  cov_period: cover property ($rose(period_timer_flag_out));
  cov_wake: cover property ($rose(wake_out));
endmodule // ccpc_channel_checker
bind ccpc_channel ccpc_channel_checker u_chk (.clk_in, .nrst_in,
  .channel_control_in, .channel_control_wr_in, .period_timer_control_in,
  .event_ext_clk_sel_in, .sleep_in, .trigger_source_sel_in,
  .match_int_enable_in, .flag_clear_in, .channel_output_out,
  .channel_output_internal_out, .channel_match_flag_out,
  .period_timer_flag_out, .conversion_trigger_out, .wake_out,
  .event_timer_count_out, .period_counter_out);
`default_nettype wire

/* sim/ccpc_channel_tb.sv */
// Self-checking bench for the compare/PWM channel.
`default_nettype none
`timescale 1ns/1ns
module ccpc_channel_tb;
  import ccpc_pkg::*;
  logic clk_in, nrst_in, ctrl_wr, cmp_wr, ext_sel, ext_tick, sleep_in;
  logic trig_sel, flag_clr, drive_en, measure, pin, mflag, pflag, trig;
  logic inten, wake;
  logic [7:0] ctrl, high_cnt, trig_cnt;
  logic [15:0] cmp, ecount;
  ccpc_ptimer_t ptc;
  int failures, checks_done, cnt, ntrig;
  logic [7:0] c_ctrl [6] = '{8'h88, 8'h82, 8'h88, 8'h89, 8'h88, 8'h8A};
  logic c_sel [6] = '{1, 0, 1, 1, 1, 1};
  logic c_exp [6] = '{1, 0, 1, 0, 1, 0};
  logic [7:0] p_ctrl [5] = '{8'h8F, 8'h8F, 8'h8F, 8'h9F, 8'h8F};
  logic [15:0] p_cmp [5] = '{16'h0006, 0, 16'h0014, 16'h0180, 16'h0006};
  logic [1:0] p_pre [5] = '{PRESC_1, PRESC_1, PRESC_1, PRESC_1, PRESC_4};
  int p_win [5] = '{32, 32, 32, 32, 128};
  // The registered clear lands one clock after the time base match.
  int p_exp [5] = '{14, 0, 32, 14, 50};
  ccpc_channel u_dut (.clk_in, .nrst_in, .channel_control_in(ctrl),
    .channel_control_wr_in(ctrl_wr), .compare_value_pair_in(cmp),
    .compare_value_wr_in(cmp_wr), .period_timer_control_in(ptc),
    .event_timer_run_in(1'b1), .event_ext_clk_sel_in(ext_sel),
    .event_ext_tick_in(ext_tick), .sleep_in,
    .trigger_source_sel_in(trig_sel), .match_int_enable_in(inten),
    .flag_clear_in(flag_clr), .channel_output_out(pin),
    .channel_output_internal_out(), .channel_match_flag_out(mflag),
    .period_timer_flag_out(pflag), .conversion_trigger_out(trig),
    .wake_out(wake), .event_timer_count_out(ecount), .period_counter_out());
  ccpc_pin_load u_load (.clk_in, .nrst_in, .pin_in(pin),
    .drive_en_in(drive_en), .measure_in(measure), .trigger_in(trig),
    .high_cnt_out(high_cnt), .trig_cnt_out(trig_cnt));
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      failures++;
      $display("unexpected at %0t: got %h want %h", $time, seen, exp);
    end
  endtask
  task automatic stop_test();
    $display("failures %0d checks_done %0d", failures, checks_done);
    if (failures == 0 && checks_done > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // Every write also clears both sticky flags.
  task automatic wr(input logic [7:0] c, input logic [15:0] v);
    @(negedge clk_in);
    ctrl = c;
    cmp = v;
    ctrl_wr = 1'b1;
    cmp_wr = 1'b1;
    flag_clr = 1'b1;
    @(negedge clk_in);
    ctrl_wr = 1'b0;
    cmp_wr = 1'b0;
    flag_clr = 1'b0;
  endtask
  task automatic tick(input int n);
    repeat (n) begin
      @(negedge clk_in);
      ext_tick = 1'b1;
      @(negedge clk_in);
      ext_tick = 1'b0;
    end
    cnt += n;
    repeat (3) @(negedge clk_in);
  endtask
  initial begin
    clk_in = 1'b0;
    forever #2 clk_in = ~clk_in;
  end
  initial begin
    #40000;
    failures++;
    stop_test();
  end
  initial begin
    {ctrl, ctrl_wr, cmp, cmp_wr, ext_tick, sleep_in, trig_sel} = '0;
    {flag_clr, drive_en, measure, failures, checks_done, cnt, ntrig} = '0;
    ext_sel = 1'b1;
    inten = 1'b1;
    ptc = '{1'b1, PRESC_1, 8'h03};
    nrst_in = 1'b0;
    repeat (12) @(negedge clk_in);
    nrst_in = 1'b1;
    for (int i = 0; i < 6; i++) begin
      trig_sel = c_sel[i];
      wr(c_ctrl[i], 16'(cnt + 3));
      tick(3);
      ntrig += int'(c_sel[i]);
      check(16'(pin), 16'(c_exp[i]));
      check(16'(mflag), 16'h0001);
      check(16'(wake), 16'h0001);
      check(ecount, 16'(cnt));
      check(16'(trig_cnt), 16'(ntrig));
    end
    // Toggle and clear: the timer restarts at the tick after the match.
    wr(8'h81, 16'(cnt + 3));
    tick(3);
    check(16'(pin), 16'h0001);
    tick(1);
    cnt = 0;
    check(ecount, 16'(cnt));
    wr(8'h81, 16'(cnt + 2));
    tick(2);
    inten = 1'b0;
    @(negedge clk_in);
    check(16'(wake), 16'h0000);
    inten = 1'b1;
    // A compare write between match and tick cancels the clear.
    wr(8'h81, 16'h0040);
    tick(1);
    check(ecount, 16'(cnt));
    check(16'(pin), 16'h0000);
    drive_en = 1'b1;
    measure = 1'b1;
    wr(8'h8B, 16'(cnt + 1));
    tick(1);
    check(16'(high_cnt), 16'h0001);
    tick(1);
    cnt = 0;
    check(ecount, 16'(cnt));
    measure = 1'b0;
    drive_en = 1'b0;
    wr(8'h88, 16'(cnt + 1));
    tick(1);
    check(16'(pin), 16'h0001);
    wr(8'h00, cmp);
    repeat (2) @(negedge clk_in);
    check(16'(pin), 16'h0000);
    ext_sel = 1'b0;
    sleep_in = 1'b1;
    repeat (40) @(negedge clk_in);
    check(ecount, 16'(cnt));
    wr(8'h88, 16'(cnt + 2));
    ext_sel = 1'b1;
    tick(2);
    check(ecount, 16'(cnt));
    check(16'(wake), 16'h0001);
    sleep_in = 1'b0;
    ext_sel = 1'b0;
    repeat (8) @(negedge clk_in);
    cnt += 2;
    check(ecount, 16'(cnt));
    ext_sel = 1'b1;
    wr(8'h00, cmp);
    for (int k = 0; k < 100 && pflag !== 1'b1; k++) @(negedge clk_in);
    check(16'(pflag), 16'h0001);
    drive_en = 1'b1;
    for (int i = 0; i < 5; i++) begin
      ptc.prescale_sel = p_pre[i];
      wr(p_ctrl[i], p_cmp[i]);
      repeat (p_win[i] + 40) @(negedge clk_in);
      measure = 1'b1;
      repeat (p_win[i]) @(negedge clk_in);
      check(16'(high_cnt), 16'(p_exp[i]));
      measure = 1'b0;
    end
    stop_test();
  end
endmodule // ccpc_channel_tb
`default_nettype wire
